// ==== logic/power_loss_restart_supervisor.sv ====
// What this block does
// - The restart mode picks trip, retry from zero, retry matched, matched then stop and trip, or retry from input.
// - In a retry mode restarts are tried up to the retry count and the block trips once they are used up.
// - Outage retry select 00 allows 16 attempts and 01 allows unlimited attempts with no exhaustion trip.
// - A restart follows only if the outage stays within the outage time limit, otherwise the block trips.
// - Each restart attempt is preceded by the programmed restart wait time.
// - The stopped outage trip select decides whether an outage while stopped trips (01) or not (00, 02).
// - Below the zero restart threshold a matched restart becomes a restart from zero frequency.
// - Undervoltage lasting 40 seconds trips with the undervoltage code even while retrying.
// - Undervoltage retry select 00 allows 16 attempts and 01 allows unlimited attempts.
// - After an overcurrent fault one restart is made per fault, as the attempt count is zero at each fault, so the one to three limit never trips.
// - If the trip cause is still present when the restart wait ends, the block trips.
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module power_loss_restart_supervisor
    import restart_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // Supply monitor and drive status
    input  wire logic        PWR_FAIL,
    input  wire logic        UNDERVOLT,
    input  wire logic        FAULT_OVC,
    input  wire logic        RUN_CMD,
    input  wire logic [15:0] MOTOR_FREQ,
    input  wire logic        RESTART_DONE,
    // Motor output stage control
    output logic             OUTPUT_OFF,
    output logic             RESTART_REQ,
    output logic      [1:0]  RESTART_KIND,
    output logic             DECEL_STOP_REQ,
    output logic             TRIP,
    output logic      [2:0]  TRIP_CODE,
    output logic             IRQ
);

    typedef enum logic [2:0] {ST_RUN, ST_OUTAGE, ST_WAIT, ST_RESTART, ST_DECEL, ST_TRIP} state_type;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    state_type   state_ff;
    state_type   nxt_state;
    cause_type   cause_ff;
    cause_type   nxt_cause;
    logic [4:0]  att_ff;
    logic [4:0]  nxt_att;
    logic [9:0]  cnt_ff;
    logic [9:0]  nxt_cnt;
    logic [2:0]  trip_ff;
    logic [2:0]  nxt_trip;
    logic [8:0]  uv_cnt_ff;
    logic [23:0] tick_cnt_ff;
    logic [31:0] ctrl_ff;
    logic [31:0] olim_ff;
    logic [31:0] wait_ff;
    logic [31:0] thresh_ff;
    logic [31:0] irq_st_ff;
    logic [31:0] irq_mk_ff;
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic        req_ff;
    logic [1:0]  kind_ff;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic [31:0] bmask;
    logic        bus_req;
    logic        bus_wr;
    logic [31:0] rd_mux;
    logic [31:0] status_w;
    logic [31:0] irq_evt;
    logic        trip_clear;
    cfg_type     cfg;

    for (genvar g = 0; g < 4; g++) begin : g_bmask
        assign bmask[8*g +: 8] = {8{SEL_I[g]}};
    end

    assign bus_req    = CYC_I & STB_I & ~ack_ff;
    assign bus_wr     = bus_req & WE_I;
    assign trip_clear = bus_wr & (ADR_I == OFS_CMD) & SEL_I[0] & DAT_I[POS_CMD_CLR];
    assign status_w   = {19'h0, att_ff, 1'b0, trip_ff, 1'b0, 3'(state_ff)};

    assign rd_mux = (ADR_I == OFS_CTRL)   ? ctrl_ff   :
                    (ADR_I == OFS_OLIM)   ? olim_ff   :
                    (ADR_I == OFS_WAIT)   ? wait_ff   :
                    (ADR_I == OFS_THRESH) ? thresh_ff :
                    (ADR_I == OFS_STATUS) ? status_w  :
                    (ADR_I == OFS_IRQ_ST) ? irq_st_ff :
                    (ADR_I == OFS_IRQ_MK) ? irq_mk_ff : 32'h0;

    assign cfg.restart_mode_select          = ctrl_ff[POS_MODE +: 3];
    assign cfg.stopped_outage_trip_select   = ctrl_ff[POS_STOPTRIP +: 2];
    assign cfg.outage_retry_count_select    = ctrl_ff[POS_OUT_UNL];
    assign cfg.undervolt_retry_count_select = ctrl_ff[POS_UV_UNL];
    assign cfg.overload_retry_select        = ctrl_ff[POS_OVC_MODE +: 3];
    assign cfg.overload_retry_limit         = ctrl_ff[POS_OVC_LIM +: 2];
    assign cfg.outage_time_limit            = olim_ff[7:0];
    assign cfg.restart_wait_time            = wait_ff[9:0];
    assign cfg.zero_restart_freq_threshold  = thresh_ff[15:0];

    // ----------------------------------------
    // Timebase and supervision terms
    // ----------------------------------------
    logic       tick;
    logic       pwr_bad;
    logic [2:0] act_mode;
    logic       cause_live;
    logic       limit_hit;
    logic [2:0] cause_code;
    logic [4:0] ovc_lim;
    logic [1:0] kind_sel;
    logic       uv_expired;

    // Free-running tick: interval starts are not phase aligned, so times resolve to one tick
    assign tick       = (tick_cnt_ff == 24'(TICK_CYCLES - 1));
    assign pwr_bad    = PWR_FAIL | UNDERVOLT;
    assign act_mode   = (cause_ff == CAUSE_OVC) ? cfg.overload_retry_select : cfg.restart_mode_select;
    assign cause_live = (cause_ff == CAUSE_OVC) ? FAULT_OVC : pwr_bad;
    assign cause_code = (cause_ff == CAUSE_OVC) ? TRIP_OVC :
                        (cause_ff == CAUSE_UV)  ? TRIP_UNDERVOLT : TRIP_POWER;
    // A limit of zero behaves as one so an overload always gets one attempt
    assign ovc_lim    = (cfg.overload_retry_limit == 2'h0) ? 5'h1 : {3'h0, cfg.overload_retry_limit};
    assign limit_hit  = (cause_ff == CAUSE_OVC) ? (att_ff >= ovc_lim) :
                        (cause_ff == CAUSE_UV)  ? (~cfg.undervolt_retry_count_select &
                                                   (att_ff >= RETRY_FINITE_MAX)) :
                        (~cfg.outage_retry_count_select & (att_ff >= RETRY_FINITE_MAX));
    assign kind_sel   = (act_mode == MODE_INPUT) ? KIND_INPUT :
                        (act_mode == MODE_ZERO)  ? KIND_ZERO  :
                        (MOTOR_FREQ < cfg.zero_restart_freq_threshold) ? KIND_ZERO : KIND_MATCH;
    assign uv_expired = (uv_cnt_ff >= 9'(UV_TRIP_TICKS));

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic       restart_go;
    logic       trip_go;
    logic       outage_go;
    logic [2:0] tcode;

    always_comb begin
        nxt_state  = state_ff;
        nxt_cause  = cause_ff;
        nxt_att    = att_ff;
        nxt_cnt    = (tick && cnt_ff != 10'h3ff) ? cnt_ff + 10'h1 : cnt_ff;
        nxt_trip   = trip_ff;
        restart_go = 1'b0;
        trip_go    = 1'b0;
        outage_go  = 1'b0;
        tcode      = TRIP_NONE;
        case (state_ff)
            ST_RUN: begin
                nxt_cnt = 10'h0;
                if (pwr_bad) begin
                    nxt_cause = (UNDERVOLT & ~PWR_FAIL) ? CAUSE_UV : CAUSE_PWR;
                    if (!RUN_CMD) begin
                        // Stopped or decelerating after run removed
                        trip_go = (cfg.stopped_outage_trip_select == STOP_TRIP);
                        tcode   = (UNDERVOLT & ~PWR_FAIL) ? TRIP_UNDERVOLT : TRIP_POWER;
                    end else if (cfg.restart_mode_select == MODE_TRIP) begin
                        trip_go = 1'b1;
                        tcode   = (UNDERVOLT & ~PWR_FAIL) ? TRIP_UNDERVOLT : TRIP_POWER;
                    end else begin
                        nxt_state = ST_OUTAGE;
                        outage_go = 1'b1;
                    end
                end else if (FAULT_OVC && RUN_CMD) begin
                    nxt_cause = CAUSE_OVC;
                    tcode     = TRIP_OVC;
                    if (cfg.overload_retry_select == MODE_TRIP) begin
                        trip_go = 1'b1;
                    end else begin
                        nxt_state = ST_WAIT;
                    end
                end
            end
            ST_OUTAGE: begin
                tcode = cause_code;
                if (cnt_ff > {2'h0, cfg.outage_time_limit}) begin
                    trip_go = 1'b1;
                end else if (!pwr_bad) begin
                    nxt_cnt = 10'h0;
                    if (limit_hit) begin
                        trip_go = 1'b1;
                    end else begin
                        nxt_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                tcode = cause_code;
                if (cnt_ff >= cfg.restart_wait_time) begin
                    if (cause_live) begin
                        trip_go = 1'b1;
                    end else if (limit_hit) begin
                        trip_go = 1'b1;
                    end else begin
                        restart_go = 1'b1;
                        nxt_att    = (att_ff == 5'h1f) ? att_ff : att_ff + 5'h1;
                        nxt_state  = ST_RESTART;
                    end
                end
            end
            ST_RESTART: begin
                nxt_cnt = 10'h0;
                if (pwr_bad) begin
                    nxt_cause = (UNDERVOLT & ~PWR_FAIL) ? CAUSE_UV : CAUSE_PWR;
                    nxt_state = ST_OUTAGE;
                    outage_go = 1'b1;
                end else if (RESTART_DONE) begin
                    if (act_mode == MODE_MATCH_STOP) begin
                        nxt_state = ST_DECEL;
                    end else begin
                        nxt_att   = 5'h0;
                        nxt_state = ST_RUN;
                    end
                end
            end
            ST_DECEL: begin
                tcode   = TRIP_DECEL_STOP;
                trip_go = (MOTOR_FREQ == 16'h0);
            end
            ST_TRIP: begin
                if (trip_clear) begin
                    nxt_state = ST_RUN;
                    nxt_att   = 5'h0;
                    nxt_trip  = TRIP_NONE;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
        // Long undervoltage overrides every retry state
        if (uv_expired && state_ff != ST_RUN && state_ff != ST_TRIP) begin
            trip_go = 1'b1;
            tcode   = TRIP_UNDERVOLT;
        end
        if (trip_go) begin
            restart_go = 1'b0;
            nxt_state  = ST_TRIP;
            nxt_trip   = tcode;
        end
    end

    assign irq_evt = {29'h0, trip_go, restart_go, outage_go};

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= ST_RUN;
            cause_ff <= CAUSE_PWR;
            att_ff   <= 5'h0;
            cnt_ff   <= 10'h0;
            trip_ff  <= TRIP_NONE;
            req_ff   <= 1'b0;
            kind_ff  <= KIND_ZERO;
        end else begin
            state_ff <= nxt_state;
            cause_ff <= nxt_cause;
            att_ff   <= nxt_att;
            cnt_ff   <= nxt_cnt;
            trip_ff  <= nxt_trip;
            req_ff   <= restart_go;
            kind_ff  <= restart_go ? kind_sel : kind_ff;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            tick_cnt_ff <= 24'h0;
            uv_cnt_ff   <= 9'h0;
        end else begin
            tick_cnt_ff <= tick ? 24'h0 : tick_cnt_ff + 24'h1;
            uv_cnt_ff   <= !UNDERVOLT ? 9'h0 : (tick && !uv_expired) ? uv_cnt_ff + 9'h1 : uv_cnt_ff;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_ff   <= RST_CTRL;
            olim_ff   <= RST_OLIM;
            wait_ff   <= RST_WAIT;
            thresh_ff <= RST_THRESH;
            irq_mk_ff <= 32'h0;
        end else if (bus_wr) begin
            if (ADR_I == OFS_CTRL)   ctrl_ff   <= ((ctrl_ff & ~bmask) | (DAT_I & bmask)) & MSK_CTRL;
            if (ADR_I == OFS_OLIM)   olim_ff   <= ((olim_ff & ~bmask) | (DAT_I & bmask)) & MSK_OLIM;
            if (ADR_I == OFS_WAIT)   wait_ff   <= ((wait_ff & ~bmask) | (DAT_I & bmask)) & MSK_WAIT;
            if (ADR_I == OFS_THRESH) thresh_ff <= ((thresh_ff & ~bmask) | (DAT_I & bmask)) & MSK_THRESH;
            if (ADR_I == OFS_IRQ_MK) irq_mk_ff <= ((irq_mk_ff & ~bmask) | (DAT_I & bmask)) & MSK_IRQ;
        end
    end

    // Status bits: a new event in the clearing cycle stays set
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_st_ff <= 32'h0;
        end else begin
            irq_st_ff <= ((irq_st_ff & ~((bus_wr && ADR_I == OFS_IRQ_ST) ? (DAT_I & bmask) : 32'h0)) | irq_evt)
                         & MSK_IRQ;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= bus_req;
            dat_ff <= (bus_req && !WE_I) ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign ACK_O          = ack_ff;
    assign DAT_O          = dat_ff;
    assign RESTART_REQ    = req_ff;
    assign RESTART_KIND   = kind_ff;
    assign OUTPUT_OFF     = (state_ff == ST_OUTAGE) | (state_ff == ST_WAIT) | (state_ff == ST_TRIP);
    assign DECEL_STOP_REQ = (state_ff == ST_DECEL);
    assign TRIP           = (state_ff == ST_TRIP);
    assign TRIP_CODE      = trip_ff;
    assign IRQ            = |(irq_st_ff & irq_mk_ff);

endmodule

// ==== logic/restart_pkg.sv ====
package restart_pkg;

    // ----------------------------------------
    // Timebase
    // ----------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TICK_TIME_MS    = 100;
    localparam int TICK_CYCLES_DEF = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int UV_TRIP_TIME_S  = 40;
    localparam int UV_TRIP_TICKS   = UV_TRIP_TIME_S * 1000 / TICK_TIME_MS;
    localparam logic [4:0] RETRY_FINITE_MAX = 5'h10;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_OLIM   = 8'h04;
    localparam logic [7:0] OFS_WAIT   = 8'h08;
    localparam logic [7:0] OFS_THRESH = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_ST = 8'h14;
    localparam logic [7:0] OFS_IRQ_MK = 8'h18;
    localparam logic [7:0] OFS_CMD    = 8'h1c;

    // ----------------------------------------
    // Field positions and writable masks
    // ----------------------------------------
    localparam int POS_MODE     = 0;
    localparam int POS_STOPTRIP = 4;
    localparam int POS_OUT_UNL  = 8;
    localparam int POS_UV_UNL   = 9;
    localparam int POS_OVC_MODE = 12;
    localparam int POS_OVC_LIM  = 16;
    localparam int POS_ST_STATE = 0;
    localparam int POS_ST_TRIP  = 4;
    localparam int POS_ST_ATT   = 8;
    localparam int POS_IRQ_OUT  = 0;
    localparam int POS_IRQ_RST  = 1;
    localparam int POS_IRQ_TRIP = 2;
    localparam int POS_CMD_CLR  = 0;
    localparam logic [31:0] MSK_CTRL   = 32'h0003_7337;
    localparam logic [31:0] MSK_OLIM   = 32'h0000_00ff;
    localparam logic [31:0] MSK_WAIT   = 32'h0000_03ff;
    localparam logic [31:0] MSK_THRESH = 32'h0000_ffff;
    localparam logic [31:0] MSK_IRQ    = 32'h0000_0007;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [31:0] RST_CTRL   = 32'h0001_0000;
    localparam logic [31:0] RST_OLIM   = 32'h0000_000a;
    localparam logic [31:0] RST_WAIT   = 32'h0000_000a;
    localparam logic [31:0] RST_THRESH = 32'h0000_0000;

    // ----------------------------------------
    // Codes
    // ----------------------------------------
    localparam logic [2:0] MODE_TRIP       = 3'h0;
    localparam logic [2:0] MODE_ZERO       = 3'h1;
    localparam logic [2:0] MODE_MATCH      = 3'h2;
    localparam logic [2:0] MODE_MATCH_STOP = 3'h3;
    localparam logic [2:0] MODE_INPUT      = 3'h4;
    localparam logic [1:0] STOP_NO_TRIP    = 2'h0;
    localparam logic [1:0] STOP_TRIP       = 2'h1;
    localparam logic [1:0] STOP_NO_TRIP_DEC = 2'h2;
    localparam logic [2:0] TRIP_NONE       = 3'h0;
    localparam logic [2:0] TRIP_POWER      = 3'h1;
    localparam logic [2:0] TRIP_UNDERVOLT  = 3'h2;
    localparam logic [2:0] TRIP_OVC        = 3'h3;
    localparam logic [2:0] TRIP_DECEL_STOP = 3'h4;
    localparam logic [1:0] KIND_ZERO       = 2'h0;
    localparam logic [1:0] KIND_MATCH      = 2'h1;
    localparam logic [1:0] KIND_INPUT      = 2'h2;

    typedef enum logic [1:0] {CAUSE_PWR, CAUSE_UV, CAUSE_OVC} cause_type;

    typedef struct packed {
        logic [2:0]  restart_mode_select;
        logic [1:0]  stopped_outage_trip_select;
        logic        outage_retry_count_select;
        logic        undervolt_retry_count_select;
        logic [2:0]  overload_retry_select;
        logic [1:0]  overload_retry_limit;
        logic [7:0]  outage_time_limit;
        logic [9:0]  restart_wait_time;
        logic [15:0] zero_restart_freq_threshold;
    } cfg_type;

endpackage

// ==== verification/power_loss_restart_supervisor_props.sv ====
`timescale 1ns/10ps
module power_loss_restart_supervisor_props
    import restart_pkg::*;
(
    // Clock, reset and bus
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [7:0]  ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    // Supply and output stage
    input wire logic        PWR_FAIL,
    input wire logic        UNDERVOLT,
    input wire logic        FAULT_OVC,
    input wire logic        RUN_CMD,
    input wire logic [15:0] MOTOR_FREQ,
    input wire logic        RESTART_DONE,
    input wire logic        OUTPUT_OFF,
    input wire logic        RESTART_REQ,
    input wire logic [1:0]  RESTART_KIND,
    input wire logic        DECEL_STOP_REQ,
    input wire logic        TRIP,
    input wire logic [2:0]  TRIP_CODE,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    wire bus_req = CYC_I & STB_I;
    wire clr_cmd = bus_req & WE_I & (ADR_I == OFS_CMD);

    a_ack_answer: assert property (bus_req && !ACK_O |=> ACK_O) else $error("no ack after request");
    a_ack_single: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
    a_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("read data outside ack");
    a_req_pulse: assert property (RESTART_REQ |=> !RESTART_REQ) else $error("restart request too long");
    a_kind_with_req: assert property ($changed(RESTART_KIND) |-> RESTART_REQ) else $error("kind moved alone");
    a_trip_held: assert property (TRIP && !clr_cmd |=> TRIP) else $error("trip dropped");
    a_trip_coded: assert property (TRIP |-> TRIP_CODE != TRIP_NONE) else $error("trip without code");
    a_trip_no_req: assert property (TRIP |-> !RESTART_REQ) else $error("restart while tripped");
    a_req_output_on: assert property (RESTART_REQ |-> !OUTPUT_OFF) else $error("restart with output off");

    c_match: cover property (RESTART_REQ && RESTART_KIND == KIND_MATCH);
    c_trip_pwr: cover property (TRIP && TRIP_CODE == TRIP_POWER);
    c_irq: cover property (IRQ);
endmodule

bind power_loss_restart_supervisor power_loss_restart_supervisor_props u_props (
    .CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
    .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .PWR_FAIL(PWR_FAIL), .UNDERVOLT(UNDERVOLT),
    .FAULT_OVC(FAULT_OVC), .RUN_CMD(RUN_CMD), .MOTOR_FREQ(MOTOR_FREQ), .RESTART_DONE(RESTART_DONE),
    .OUTPUT_OFF(OUTPUT_OFF), .RESTART_REQ(RESTART_REQ), .RESTART_KIND(RESTART_KIND),
    .DECEL_STOP_REQ(DECEL_STOP_REQ), .TRIP(TRIP), .TRIP_CODE(TRIP_CODE), .IRQ(IRQ));

// ==== verification/motor_stage_model.sv ====
`timescale 1ns/10ps
module motor_stage_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // From supervisor
    input  wire logic        restart_req,
    input  wire logic        decel_req,
    // Bench knobs: stall never answers, lat sets answer delay
    input  wire logic        stall,
    input  wire logic [3:0]  lat,
    input  wire logic [15:0] freq_set,
    // To supervisor
    output logic      [15:0] motor_freq,
    output logic             restart_done
);
    logic [3:0]  cnt_ff;
    logic [15:0] spin_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff       <= 4'h0;
            restart_done <= 1'b0;
            spin_ff      <= 16'h0;
        end else begin
            restart_done <= (cnt_ff == 4'h1);
            if (restart_req && !stall)
                cnt_ff <= lat;
            else if (cnt_ff != 4'h0)
                cnt_ff <= cnt_ff - 4'h1;
            // Coasting down is coarse so a decel stop ends in tens of cycles
            spin_ff <= !decel_req ? freq_set : (spin_ff > 16'h0100 ? spin_ff - 16'h0100 : 16'h0);
        end
    end

    assign motor_freq = spin_ff;
endmodule

// ==== verification/power_loss_restart_supervisor_bench.sv ====
`timescale 1ns/10ps
module power_loss_restart_supervisor_bench;
    import restart_pkg::*;
    localparam int TK = 4;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, pwr = 0, uv = 0, ovc = 0, run = 0, stall = 0;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0, lat = 1;
    logic [31:0] wdat = 0;
    logic [15:0] fset = 0;
    wire [31:0] rdat;
    wire [15:0] mfreq;
    wire [2:0] code;
    wire [1:0] kind;
    wire ack, done, off, req, decel, trip, irq;
    int n_errors = 0, num_checks = 0, cycles = 0, n;

    power_loss_restart_supervisor #(.TICK_CYCLES(TK)) u_dut (
        .CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat),
        .DAT_O(rdat), .ACK_O(ack), .PWR_FAIL(pwr), .UNDERVOLT(uv), .FAULT_OVC(ovc), .RUN_CMD(run),
        .MOTOR_FREQ(mfreq), .RESTART_DONE(done), .OUTPUT_OFF(off), .RESTART_REQ(req),
        .RESTART_KIND(kind), .DECEL_STOP_REQ(decel), .TRIP(trip), .TRIP_CODE(code), .IRQ(irq));
    motor_stage_model u_motor (.clk(clk), .rst(rst), .restart_req(req), .decel_req(decel), .stall(stall),
        .lat(lat), .freq_set(fset), .motor_freq(mfreq), .restart_done(done));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat;
        if (k >= 20) chk("ack", 0, 1);
        {cyc, stb, we} <= 3'b000;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] q;
        wb(1'b1, a, d, s, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, 4'hf, q);
        chk(nm, q, e);
    endtask

    // Wait for request (0) or trip (1)
    task automatic wait_on(input int which);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (((which == 0) ? req : trip) !== 1'b1 && n < 400);
        if (n >= 400) chk("wait_on", 0, 1);
    endtask

    task automatic outage(input int len, input logic by_uv);
        @(posedge clk);
        if (by_uv) uv <= 1'b1;
        else pwr <= 1'b1;
        repeat (len) @(posedge clk);
        {pwr, uv} <= 2'b00;
    endtask

    task automatic clear_trip();
        chk("off", off, 1);
        wr(OFS_CMD, 32'h1);
        chk("trip clear", trip, 0);
    endtask

    function automatic logic [1:0] exp_kind(input logic [2:0] m, input logic [15:0] f, input logic [15:0] th);
        if (m == MODE_INPUT) return KIND_INPUT;
        if (m == MODE_ZERO || f < th) return KIND_ZERO;
        return KIND_MATCH;
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        logic [2:0] m;
        void'($urandom(32'h87cb1f36));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd("ctrl", OFS_CTRL, RST_CTRL);
        rd("olim", OFS_OLIM, RST_OLIM);
        rd("wait", OFS_WAIT, RST_WAIT);
        rd("thresh", OFS_THRESH, RST_THRESH);
        rd("unmapped", 8'h20, 32'h0);
        wr(OFS_OLIM, 32'h3);
        wr(OFS_WAIT, 32'h3);
        wr(OFS_THRESH, 32'h1000);
        wr(OFS_THRESH, 32'hffff, 4'h1);
        rd("thresh sel", OFS_THRESH, 32'h10ff);
        wr(OFS_IRQ_MK, 32'h7);
        run <= 1'b1;
        // Zero, matched, matched below threshold, input frequency
        for (int i = 0; i < 4; i++) begin
            m = (i == 0) ? MODE_ZERO : (i == 3) ? MODE_INPUT : MODE_MATCH;
            fset <= (i == 2) ? 16'h0800 : 16'h2000 + 16'($urandom_range(0, 4095));
            lat <= 4'($urandom_range(1, 8));
            wr(OFS_CTRL, {29'h0, m});
            outage($urandom_range(1, 6), 1'($urandom));
            wait_on(0);
            chk("wait len", n >= 2 * TK, 1);
            chk("kind", kind, exp_kind(m, fset, 16'h10ff));
            repeat (12) @(posedge clk);
            rd("status after", OFS_STATUS, 32'h0);
        end
        rd("irq status", OFS_IRQ_ST, 32'h3);
        chk("irq on", irq, 1);
        wr(OFS_IRQ_MK, 32'h0);
        chk("irq masked", irq, 0);
        wr(OFS_IRQ_MK, 32'h7);
        wr(OFS_IRQ_ST, 32'h7);
        chk("irq cleared", irq, 0);
        // Matched restart, decelerate, stop, trip
        wr(OFS_CTRL, {29'h0, MODE_MATCH_STOP});
        outage(2, 0);
        repeat (30) @(posedge clk);
        chk("decel", decel, 1);
        wait_on(1);
        chk("decel trip", code, TRIP_DECEL_STOP);
        clear_trip();
        wr(OFS_CTRL, {29'h0, MODE_TRIP});
        outage(2, 0);
        wait_on(1);
        chk("mode trip", code, TRIP_POWER);
        clear_trip();
        wr(OFS_CTRL, {29'h0, MODE_MATCH});
        outage(40, 0);
        wait_on(1);
        chk("long outage", code, TRIP_POWER);
        clear_trip();
        run <= 1'b0;
        wr(OFS_CTRL, 32'h12);
        outage(2, 0);
        wait_on(1);
        chk("stopped trip", trip, 1);
        clear_trip();
        for (int i = 0; i < 2; i++) begin
            wr(OFS_CTRL, (i == 0) ? 32'h02 : 32'h22);
            outage(2, 0);
            repeat (20) @(posedge clk);
            chk("stopped no trip", trip, 0);
        end
        // Attempts used up without a completed restart
        run <= 1'b1;
        stall <= 1'b1;
        wr(OFS_CTRL, {29'h0, MODE_ZERO});
        repeat (16) begin
            outage(2, 0);
            wait_on(0);
        end
        outage(2, 0);
        wait_on(1);
        chk("retry exhausted", trip, 1);
        clear_trip();
        wr(OFS_CTRL, 32'h101);
        repeat (17) begin
            outage(2, 0);
            wait_on(0);
            chk("unlimited req", req, 1);
        end
        rd("attempts", OFS_STATUS, 32'h1103);
        stall <= 1'b0;
        outage(2, 0);
        wait_on(0);
        repeat (12) @(posedge clk);
        rd("attempts clear", OFS_STATUS, 32'h0);
        // Overload cause still present when the wait ends
        wr(OFS_CTRL, 32'h1_1002);
        ovc <= 1'b1;
        wait_on(1);
        chk("ovc trip", code, TRIP_OVC);
        ovc <= 1'b0;
        clear_trip();
        wrap_up();
    end
endmodule
